// [hdl/ldmf_core.sv]
// Functional notes
// - low logic supply forces standalone mode
// - bus and registers work without main supply
// - low-impedance main supply delays interface start
// - global dim input gates all channels
// - wait 15 us after dim rise
// - fault drives shared flag line high
// - sense flag line, react per settings
// - registers choose flag sources, overtemp included
// - supply comparator picks flag driver rail
// - flag on open, thermal shutdown, resistor short
// - global dimming makes flag follow dim input
// - register dimming keeps flag steadily asserted
// - error detection valid within 70 us
// - select pin picks output set a/b
// - non-volatile sets mirrored in shadow registers
// - otp select pin enables writes to sets a/b
// - force bit moves device to bus mode
// - logic supply loss clears force bit
//
// Added by the designer: the address map and register access over Avalon-MM.
`default_nettype none
module ldmf_core import ldmf_pkg::*; #(
  parameter int N_CH = NCH_DEF,
  parameter int ERR_CYC = ERR_VALID_CYC,
  parameter int STEP_CYC = LOCAL_STEP_CYC,
  parameter logic [REG_W-1:0] NVM_SET_A = NVM_SET_A_DEF,
  parameter logic [REG_W-1:0] NVM_SET_B = NVM_SET_B_DEF
) (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic [ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic logic_supply_sense_in,
  input wire logic main_supply_in,
  input wire logic main_supply_low_z_in,
  input wire logic otp_select_in,
  input wire logic config_set_select_pin_in,
  input wire logic global_dim_input_in,
  input wire logic power_good_input_in,
  input wire logic [N_CH-1:0] open_fault_in,
  input wire logic thermal_shutdown_in,
  input wire logic overtemp_in,
  input wire logic current_set_resistor_short_in,
  input wire logic fault_flag_in,
  output logic fault_flag_out,
  output logic fault_flag_oe_n_out,
  output logic flag_rail_logic_out,
  output logic [N_CH-1:0] channel_on_out,
  output logic standalone_mode_out,
  output logic error_detect_valid_out
);
  localparam int ERR_W = $clog2(ERR_CYC + 1);
  localparam int WAKE_W = $clog2(DIM_WAKE_CYC + 1);
  localparam int STEP_W = $clog2(STEP_CYC + 1);

  generate
    if (N_CH < 1 || N_CH > REG_W || ERR_CYC <= PIPE_LAT || STEP_CYC < 1) begin : g_bad
      $error("ldmf_core: unsupported parameter values");
    end
  endgenerate

  ldmf_sync_if sif ();
  assign sif.raw = {power_good_input_in, global_dim_input_in, config_set_select_pin_in};

  ldmf_sync u_sync (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .s(sif.sync_side)
  );

  logic set_sel;
  logic dim_in;
  logic pg_in;
  assign set_sel = sif.sync[0];
  assign dim_in = sif.sync[1];
  assign pg_in = sif.sync[2];

  logic [REG_W-1:0] ctrl_q, ctrl_d;
  logic [REG_W-1:0] bus_set_q, bus_set_d;
  logic [REG_W-1:0] set_a_q, set_a_d;
  logic [REG_W-1:0] set_b_q, set_b_d;
  logic [DUTY_W-1:0] duty_q, duty_d;
  logic ext_seen_q, ext_seen_d;
  logic started_q, started_d;
  logic main_prev_q, main_prev_d;
  logic [WAKE_W-1:0] wake_q, wake_d;
  logic dim_ready_q, dim_ready_d;
  logic [ERR_W-1:0] err_cnt_q, err_cnt_d;
  logic err_valid_q, err_valid_d;
  logic [STEP_W-1:0] step_q, step_d;
  logic [DUTY_W-1:0] pwm_q, pwm_d;
  logic wait_q, wait_d;
  logic [31:0] rdata_q, rdata_d;
  logic [N_CH-1:0] chan_q, chan_d;
  logic flag_out_q, flag_out_d;
  logic flag_oe_n_q, flag_oe_n_d;
  logic flag_rail_q, flag_rail_d;
  logic standalone_q, standalone_d;

  logic [REG_W-1:0] wmask;
  logic [REG_W-1:0] status;
  logic standalone;
  logic reg_dim;
  logic gate;
  logic [N_CH-1:0] active_set;
  logic [N_CH-1:0] open_seen;
  logic open_hit;
  logic flag_src;
  logic ext_fault;
  logic req;

  function automatic logic [REG_W-1:0] merge(input logic [REG_W-1:0] old_v, input logic [REG_W-1:0] new_v,
                                             input logic [REG_W-1:0] m);
    merge = (old_v & ~m) | (new_v & m);
  endfunction

  always_comb begin
    wmask = {{8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
    // standalone unless logic supply and force bit
    standalone = ~(logic_supply_sense_in & ctrl_q[CTL_FORCE_BUS]);
    reg_dim = ~standalone & ctrl_q[CTL_LOCAL_DIM];
    gate = reg_dim ? (pwm_q < duty_q) : dim_ready_q;
    if (standalone) begin
      active_set = set_sel ? set_b_q[N_CH-1:0] : set_a_q[N_CH-1:0];
    end else begin
      active_set = bus_set_q[N_CH-1:0];
    end
    // open check follows the dim gate
    // register dimming checks the whole set
    open_seen = open_fault_in & active_set & (reg_dim ? {N_CH{1'b1}} : {N_CH{gate}});
    open_hit = err_valid_q & (|open_seen);
    flag_src = (open_hit & ctrl_q[CTL_SRC_OPEN]) | (thermal_shutdown_in & ctrl_q[CTL_SRC_TSD])
             | (overtemp_in & ctrl_q[CTL_SRC_OT]) | (current_set_resistor_short_in & ctrl_q[CTL_SRC_CURRENT_SET_RESISTOR]);
    // own drive would read back high, so only sense while released
    ext_fault = fault_flag_in & flag_oe_n_q;
    status = '0;
    status[ST_STANDALONE] = standalone_q;
    status[ST_EXT_SEEN] = ext_seen_q;
    status[ST_ERR_VALID] = err_valid_q;
    status[ST_FLAG_DRIVE] = ~flag_oe_n_q;
    status[ST_DIM_READY] = dim_ready_q;
    status[ST_SET_SEL] = set_sel;
    status[ST_LOGIC_OK] = logic_supply_sense_in;
    status[ST_STARTED] = started_q;
    status[ST_TSD] = thermal_shutdown_in;
    status[ST_OT] = overtemp_in;
    status[ST_CURRENT_SET_RESISTOR] = current_set_resistor_short_in;
    status[ST_OPEN] = open_hit;
    req = (avs_read_in | avs_write_in) & started_q;
  end

  always_comb begin
    ctrl_d = ctrl_q;
    bus_set_d = bus_set_q;
    set_a_d = set_a_q;
    set_b_d = set_b_q;
    duty_d = duty_q;
    ext_seen_d = ext_seen_q;
    wait_d = 1'b1;
    rdata_d = rdata_q;
    main_prev_d = main_supply_in;
    // start at once without a low-impedance main supply, else on first main supply rise
    started_d = started_q | ~main_supply_low_z_in | (main_supply_in & ~main_prev_q);
    if (req && wait_q) begin
      wait_d = 1'b0;
      rdata_d = '0;
      case (avs_address_in)
        OFS_CTRL: rdata_d[REG_W-1:0] = ctrl_q;
        OFS_BUS_SET: rdata_d[REG_W-1:0] = bus_set_q;
        OFS_SET_A: rdata_d[REG_W-1:0] = set_a_q;
        OFS_SET_B: rdata_d[REG_W-1:0] = set_b_q;
        OFS_STATUS: rdata_d[REG_W-1:0] = status;
        OFS_DUTY: rdata_d[DUTY_W-1:0] = duty_q;
        default: rdata_d = '0;
      endcase
    end
    if (req && !wait_q && avs_write_in) begin
      case (avs_address_in)
        OFS_CTRL: begin
          ctrl_d = merge(ctrl_q, avs_writedata_in[REG_W-1:0], wmask);
        end
        OFS_BUS_SET: begin
          bus_set_d = merge(bus_set_q, avs_writedata_in[REG_W-1:0], wmask);
        end
        OFS_SET_A: begin
          if (otp_select_in) begin
            set_a_d = merge(set_a_q, avs_writedata_in[REG_W-1:0], wmask);
          end
        end
        OFS_SET_B: begin
          if (otp_select_in) begin
            set_b_d = merge(set_b_q, avs_writedata_in[REG_W-1:0], wmask);
          end
        end
        OFS_STATUS: begin
          if (avs_byteenable_in[0] && avs_writedata_in[ST_EXT_SEEN]) begin
            ext_seen_d = 1'b0;
          end
        end
        OFS_DUTY: begin
          if (avs_byteenable_in[0]) begin
            duty_d = avs_writedata_in[DUTY_W-1:0];
          end
        end
        default: begin
        end
      endcase
    end
    // supply loss drops the force bit
    if (!logic_supply_sense_in) begin
      ctrl_d[CTL_FORCE_BUS] = 1'b0;
    end
    // remember an external fault, set wins
    if (ext_fault) begin
      ext_seen_d = 1'b1;
    end
  end

  always_comb begin
    wake_d = wake_q;
    dim_ready_d = dim_ready_q;
    err_cnt_d = err_cnt_q;
    err_valid_d = err_valid_q;
    step_d = step_q;
    pwm_d = pwm_q;
    // a short dim pulse leaves little on-time
    if (!dim_in) begin
      wake_d = '0;
      dim_ready_d = 1'b0;
    end else if (wake_q == WAKE_W'(DIM_WAKE_CYC)) begin
      dim_ready_d = 1'b1;
    end else begin
      wake_d = wake_q + 1'b1;
    end
    // sync latency is taken off the budget
    if (!pg_in) begin
      err_cnt_d = '0;
      err_valid_d = 1'b0;
    end else if (err_cnt_q == ERR_W'(ERR_CYC - PIPE_LAT)) begin
      err_valid_d = 1'b1;
    end else begin
      err_cnt_d = err_cnt_q + 1'b1;
    end
    // local dimming step divider
    if (step_q == STEP_W'(STEP_CYC - 1)) begin
      step_d = '0;
      pwm_d = pwm_q + 1'b1;
    end else begin
      step_d = step_q + 1'b1;
    end
  end

  always_comb begin
    standalone_d = standalone;
    flag_out_d = 1'b1;
    // high-side drive when a source is active
    flag_oe_n_d = ~flag_src;
    flag_rail_d = logic_supply_sense_in;
    if (thermal_shutdown_in || !main_supply_in || (ext_fault && ctrl_q[CTL_EXT_OFF])) begin
      chan_d = '0;
    end else begin
      chan_d = active_set & {N_CH{gate}};
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      ctrl_q <= CTRL_RST;
      bus_set_q <= BUS_SET_RST;
      set_a_q <= NVM_SET_A;
      set_b_q <= NVM_SET_B;
      duty_q <= DUTY_RST;
      ext_seen_q <= 1'b0;
      started_q <= 1'b0;
      main_prev_q <= 1'b0;
      wake_q <= '0;
      dim_ready_q <= 1'b0;
      err_cnt_q <= '0;
      err_valid_q <= 1'b0;
      step_q <= '0;
      pwm_q <= '0;
      wait_q <= 1'b1;
      rdata_q <= '0;
      chan_q <= '0;
      flag_out_q <= 1'b0;
      flag_oe_n_q <= 1'b1;
      flag_rail_q <= 1'b0;
      standalone_q <= 1'b1;
    end else begin
      ctrl_q <= ctrl_d;
      bus_set_q <= bus_set_d;
      set_a_q <= set_a_d;
      set_b_q <= set_b_d;
      duty_q <= duty_d;
      ext_seen_q <= ext_seen_d;
      started_q <= started_d;
      main_prev_q <= main_prev_d;
      wake_q <= wake_d;
      dim_ready_q <= dim_ready_d;
      err_cnt_q <= err_cnt_d;
      err_valid_q <= err_valid_d;
      step_q <= step_d;
      pwm_q <= pwm_d;
      wait_q <= wait_d;
      rdata_q <= rdata_d;
      chan_q <= chan_d;
      flag_out_q <= flag_out_d;
      flag_oe_n_q <= flag_oe_n_d;
      flag_rail_q <= flag_rail_d;
      standalone_q <= standalone_d;
    end
  end

  assign avs_readdata_out = rdata_q;
  assign avs_waitrequest_out = wait_q;
  assign fault_flag_out = flag_out_q;
  assign fault_flag_oe_n_out = flag_oe_n_q;
  assign flag_rail_logic_out = flag_rail_q;
  assign channel_on_out = chan_q;
  assign standalone_mode_out = standalone_q;
  assign error_detect_valid_out = err_valid_q;
endmodule
`default_nettype wire

// [hdl/ldmf_pkg.sv]
`default_nettype none
package ldmf_pkg;
  localparam int NCH_DEF = 12;
  localparam int REG_W = 16;
  localparam int ADDR_W = 5;
  localparam int DUTY_W = 7;
  localparam int CLK_PERIOD_NS = 8;
  localparam int CLK_HZ = 125_000_000;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_BUS_SET = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_SET_A = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_SET_B = 5'h0C;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_DUTY = 5'h14;

  // control register fields
  localparam int CTL_FORCE_BUS = 0;
  localparam int CTL_SRC_OPEN = 1;
  localparam int CTL_SRC_OT = 2;
  localparam int CTL_SRC_TSD = 3;
  localparam int CTL_SRC_CURRENT_SET_RESISTOR = 4;
  localparam int CTL_EXT_OFF = 5;
  localparam int CTL_LOCAL_DIM = 6;

  // status register fields
  localparam int ST_STANDALONE = 0;
  localparam int ST_EXT_SEEN = 1;
  localparam int ST_ERR_VALID = 2;
  localparam int ST_FLAG_DRIVE = 3;
  localparam int ST_DIM_READY = 4;
  localparam int ST_SET_SEL = 5;
  localparam int ST_LOGIC_OK = 6;
  localparam int ST_STARTED = 7;
  localparam int ST_TSD = 8;
  localparam int ST_OT = 9;
  localparam int ST_CURRENT_SET_RESISTOR = 10;
  localparam int ST_OPEN = 11;

  localparam logic [REG_W-1:0] CTRL_RST = 16'h001A;
  localparam logic [REG_W-1:0] BUS_SET_RST = 16'h0000;
  localparam logic [DUTY_W-1:0] DUTY_RST = 7'h40;
  localparam logic [REG_W-1:0] NVM_SET_A_DEF = 16'h0FFF;
  localparam logic [REG_W-1:0] NVM_SET_B_DEF = 16'h003F;

  // timing: least waits round up, longest waits round down
  localparam int DIM_WAKE_NS = 15000;
  localparam int DIM_WAKE_CYC = (DIM_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERR_VALID_NS = 70000;
  localparam int ERR_VALID_CYC = ERR_VALID_NS / CLK_PERIOD_NS;
  localparam int PIPE_LAT = 4;
  localparam int LOCAL_DIM_HZ = 220;
  localparam int LOCAL_STEP_CYC = CLK_HZ / (LOCAL_DIM_HZ * (1 << DUTY_W));
endpackage
`default_nettype wire

// [hdl/ldmf_sync.sv]
`default_nettype none
module ldmf_sync (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  ldmf_sync_if.sync_side s
);
  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : g_bit
      logic meta_q;
      logic meta_d;
      logic stab_q;
      logic stab_d;
      always_comb begin
        meta_d = s.raw[i];
        stab_d = meta_q;
      end
      // first stage feeds only the second one
      always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
          meta_q <= 1'b0;
          stab_q <= 1'b0;
        end else begin
          meta_q <= meta_d;
          stab_q <= stab_d;
        end
      end
      assign s.sync[i] = stab_q;
    end
  endgenerate
endmodule
`default_nettype wire

// [hdl/ldmf_sync_if.sv]
`default_nettype none
interface ldmf_sync_if;
  logic [2:0] raw;
  logic [2:0] sync;
  modport sync_side (input raw, output sync);
  modport user_side (output raw, input sync);
endinterface
`default_nettype wire

// [verif/ldmf_chk.sv]
`default_nettype none
module ldmf_chk import ldmf_pkg::*; #(
  parameter int N_CH = NCH_DEF,
  parameter int ERR_CYC = ERR_VALID_CYC
) (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic [ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  input wire logic avs_waitrequest_out,
  input wire logic logic_supply_sense_in,
  input wire logic global_dim_input_in,
  input wire logic power_good_input_in,
  input wire logic [N_CH-1:0] open_fault_in,
  input wire logic thermal_shutdown_in,
  input wire logic overtemp_in,
  input wire logic current_set_resistor_short_in,
  input wire logic fault_flag_oe_n_out,
  input wire logic flag_rail_logic_out,
  input wire logic [N_CH-1:0] channel_on_out,
  input wire logic standalone_mode_out,
  input wire logic error_detect_valid_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // shadow of the flag source enables, so the flag check follows software
  logic [4:1] src_q, src_d;
  logic [11:0] dim_q, dim_d;
  // cycles of power good high, saturating: the budget is too long for a delay range
  int pg_cnt_q, pg_cnt_d;
  always_comb begin
    src_d = src_q;
    if (avs_write_in && !avs_waitrequest_out && avs_address_in == OFS_CTRL && avs_byteenable_in[0]) begin
      src_d = avs_writedata_in[4:1];
    end
    dim_d = global_dim_input_in ? dim_q + ((&dim_q) ? 12'h000 : 12'h001) : 12'h000;
    pg_cnt_d = power_good_input_in ? ((pg_cnt_q < ERR_CYC) ? pg_cnt_q + 1 : pg_cnt_q) : 0;
  end
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      src_q <= CTRL_RST[4:1];
      dim_q <= 12'h000;
      pg_cnt_q <= 0;
    end else begin
      src_q <= src_d;
      dim_q <= dim_d;
      pg_cnt_q <= pg_cnt_d;
    end
  end
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  sequence s_ack;
    $fell(avs_waitrequest_out);
  endsequence
  sequence s_req_then_idle;
    $past(avs_read_in || avs_write_in) ##1 avs_waitrequest_out;
  endsequence
  AST_ACK_ONE: assert property (s_ack |-> s_req_then_idle)
    else $error("ack without request or longer than one cycle");
  AST_STANDALONE: assert property (!logic_supply_sense_in |=> standalone_mode_out)
    else $error("standalone not entered on logic supply loss");
  AST_RAIL: assert property (1'b1 |=> flag_rail_logic_out == $past(logic_supply_sense_in))
    else $error("flag rail does not follow supply sense");
  AST_TSD_OFF: assert property (thermal_shutdown_in |=> channel_on_out == '0)
    else $error("channels on during thermal shutdown");
  AST_FLAG_SRC: assert property ((thermal_shutdown_in && src_q[3]) || (current_set_resistor_short_in && src_q[4])
    |=> !fault_flag_oe_n_out)
    else $error("enabled fault source not driving flag");
  AST_OE_IDLE: assert property (!(thermal_shutdown_in || overtemp_in || current_set_resistor_short_in
    || (|open_fault_in)) |=> fault_flag_oe_n_out)
    else $error("flag driven with no fault");
  AST_ERR_VALID: assert property (pg_cnt_q == ERR_CYC |-> error_detect_valid_out)
    else $error("error detection not valid in time");
  AST_DIM_WAIT: assert property (standalone_mode_out && dim_q > 12'h004 && dim_q < 12'h753
    |-> channel_on_out == '0)
    else $error("channel on before dim wake delay");
endmodule
bind ldmf_core ldmf_chk #(.N_CH(N_CH), .ERR_CYC(ERR_CYC)) u_chk (
  .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .avs_address_in(avs_address_in),
  .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
  .avs_byteenable_in(avs_byteenable_in), .avs_waitrequest_out(avs_waitrequest_out),
  .logic_supply_sense_in(logic_supply_sense_in), .global_dim_input_in(global_dim_input_in),
  .power_good_input_in(power_good_input_in), .open_fault_in(open_fault_in),
  .thermal_shutdown_in(thermal_shutdown_in), .overtemp_in(overtemp_in),
  .current_set_resistor_short_in(current_set_resistor_short_in), .fault_flag_oe_n_out(fault_flag_oe_n_out),
  .flag_rail_logic_out(flag_rail_logic_out), .channel_on_out(channel_on_out),
  .standalone_mode_out(standalone_mode_out), .error_detect_valid_out(error_detect_valid_out));
`default_nettype wire

// [verif/ldmf_peer.sv]
`default_nettype none
module ldmf_peer (
  input wire logic clk_sys_in,
  input wire logic peer_drive_in,
  input wire logic dut_oe_n_in,
  input wire logic dut_level_in,
  output logic flag_line_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic drive_q = 1'b0;
  always_ff @(posedge clk_sys_in) begin
    drive_q <= peer_drive_in;
  end
  assign flag_line_out = drive_q | (!dut_oe_n_in & dut_level_in);
endmodule
`default_nettype wire

// [verif/led_driver_mode_and_fault_flag_tb.sv]
`default_nettype none
module led_driver_mode_and_fault_flag_tb import ldmf_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NC = 12;
  localparam int ERRC = 20;
  logic clk_sys_in, sys_rst_in, avs_read_in, avs_write_in, avs_waitrequest_out;
  logic [ADDR_W-1:0] avs_address_in;
  logic [31:0] avs_writedata_in, avs_readdata_out, r;
  logic [3:0] avs_byteenable_in;
  logic sense, main, low_z, otp_sel, set_sel, dim, pg, tsd, ot, current_set_resistor, flag_line, peer_req;
  logic flag_out, oe_n, rail, standalone, err_valid;
  logic [NC-1:0] open_f, chan;
  logic [63:0] exp_q[$];
  int n_fail = 0;
  int samples_checked = 0;
  int seed = 32'hFD0D;
  ldmf_core #(.N_CH(NC), .ERR_CYC(ERRC), .STEP_CYC(4)) DUT (
    .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .logic_supply_sense_in(sense), .main_supply_in(main),
    .main_supply_low_z_in(low_z), .otp_select_in(otp_sel), .config_set_select_pin_in(set_sel),
    .global_dim_input_in(dim), .power_good_input_in(pg), .open_fault_in(open_f),
    .thermal_shutdown_in(tsd), .overtemp_in(ot), .current_set_resistor_short_in(current_set_resistor),
    .fault_flag_in(flag_line), .fault_flag_out(flag_out), .fault_flag_oe_n_out(oe_n),
    .flag_rail_logic_out(rail), .channel_on_out(chan), .standalone_mode_out(standalone),
    .error_detect_valid_out(err_valid));
  ldmf_peer PEER (.clk_sys_in(clk_sys_in), .peer_drive_in(peer_req), .dut_oe_n_in(oe_n),
    .dut_level_in(flag_out), .flag_line_out(flag_line));
  initial begin
    clk_sys_in = 1'b0;
    forever #4 clk_sys_in = ~clk_sys_in;
  end
  task automatic stop_test();
    $display("checks %0d failures %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= wr;
    avs_read_in <= !wr;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 300);
    if (n >= 300) begin
      chk("waitrequest", 32'h0, 32'h1);
      stop_test();
    end
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] m, input logic [31:0] e);
    exp_q.push_back({m, e});
    bus(1'b0, a, 32'h0);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask
  // read data is compared at the ack edge, against the oldest note
  always @(posedge clk_sys_in) begin
    if (avs_read_in === 1'b1 && avs_waitrequest_out === 1'b0 && exp_q.size() > 0) begin
      chk("readdata", exp_q[0][31:0], avs_readdata_out & exp_q[0][63:32]);
      void'(exp_q.pop_front());
    end
  end
  initial begin
    cyc(20000);
    chk("timeout", 32'h0, 32'h1);
    stop_test();
  end
  initial begin
    {avs_read_in, avs_write_in, otp_sel, set_sel, dim, pg, tsd, ot, current_set_resistor, peer_req, main} = '0;
    {sys_rst_in, sense, low_z} = 3'b111;
    avs_byteenable_in = 4'hF;
    avs_address_in = '0;
    avs_writedata_in = '0;
    open_f = '0;
    cyc(6);
    sys_rst_in <= 1'b0;
    fork
      rd(OFS_CTRL, 32'h0000FFFF, 32'h0000001A);
      begin
        cyc(20);
        chk("wait_unstarted", 32'h1, {31'h0, avs_waitrequest_out});
        main <= 1'b1;
      end
    join
    rd(OFS_SET_A, 32'h0000FFFF, 32'h00000FFF);
    rd(OFS_SET_B, 32'h0000FFFF, 32'h0000003F);
    rd(OFS_DUTY, 32'h0000007F, 32'h00000040);
    rd(5'h18, 32'hFFFFFFFF, 32'h00000000);
    r = $random(seed);
    bus(1'b1, OFS_SET_A, r);
    rd(OFS_SET_A, 32'h0000FFFF, 32'h00000FFF);
    otp_sel <= 1'b1;
    bus(1'b1, OFS_SET_A, r);
    rd(OFS_SET_A, 32'h0000FFFF, {16'h0, r[15:0]});
    otp_sel <= 1'b0;
    // high pulse kept past the minimum
    dim <= 1'b1;
    cyc(1000);
    chk("chan_waking", 32'h0, {20'h0, chan});
    cyc(1600);
    chk("chan_a", {20'h0, r[11:0]}, {20'h0, chan});
    set_sel <= 1'b1;
    cyc(5);
    chk("chan_b", 32'h3F, {20'h0, chan});
    chk("rail_on", 32'h1, {31'h0, rail});
    bus(1'b1, OFS_BUS_SET, {16'h0, r[31:16]});
    bus(1'b1, OFS_CTRL, 32'h0000001B);
    cyc(3);
    chk("mode_bus", 32'h0, {31'h0, standalone});
    chk("chan_bus", {20'h0, r[27:16]}, {20'h0, chan});
    sense <= 1'b0;
    cyc(3);
    chk("mode_lost", 32'h1, {31'h0, standalone});
    chk("rail_off", 32'h0, {31'h0, rail});
    chk("chan_back", 32'h3F, {20'h0, chan});
    rd(OFS_CTRL, 32'h0000FFFF, 32'h0000001A);
    sense <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      {current_set_resistor, tsd} <= 2'b01 << i;
      cyc(3);
      chk("flag_oe_n", 32'h0, {31'h0, oe_n});
      chk("flag_line", 32'h1, {31'h0, flag_line});
    end
    {current_set_resistor, tsd} <= 2'b00;
    cyc(3);
    chk("flag_idle", 32'h0, {31'h0, flag_line});
    bus(1'b1, OFS_CTRL, 32'h00000012);
    tsd <= 1'b1;
    cyc(3);
    chk("flag_masked", 32'h1, {31'h0, oe_n});
    tsd <= 1'b0;
    peer_req <= 1'b1;
    cyc(4);
    peer_req <= 1'b0;
    rd(OFS_STATUS, 32'h00000002, 32'h00000002);
    bus(1'b1, OFS_STATUS, 32'h00000002);
    rd(OFS_STATUS, 32'h00000002, 32'h00000000);
    pg <= 1'b1;
    for (int i = 0; i < ERRC + 4 && err_valid !== 1'b1; i++) @(posedge clk_sys_in);
    chk("err_valid", 32'h1, {31'h0, err_valid});
    open_f <= 12'h001;
    cyc(3);
    chk("flag_open_dim", 32'h0, {31'h0, oe_n});
    dim <= 1'b0;
    cyc(5);
    chk("chan_dim_off", 32'h0, {20'h0, chan});
    chk("flag_open_dark", 32'h1, {31'h0, oe_n});
    bus(1'b1, OFS_BUS_SET, 32'h00000001);
    bus(1'b1, OFS_DUTY, 32'h00000000);
    bus(1'b1, OFS_CTRL, 32'h0000005B);
    cyc(3);
    chk("flag_open_reg", 32'h0, {31'h0, oe_n});
    chk("chan_duty_zero", 32'h0, {20'h0, chan});
    open_f <= '0;
    bus(1'b1, OFS_CTRL, 32'h0000007B);
    bus(1'b1, OFS_DUTY, 32'h0000007F);
    peer_req <= 1'b1;
    cyc(4);
    chk("chan_ext_off", 32'h0, {20'h0, chan});
    peer_req <= 1'b0;
    // second reset: a high-impedance main supply node lets the bus start at once
    {main, low_z, sys_rst_in} <= 3'b001;
    cyc(6);
    sys_rst_in <= 1'b0;
    rd(OFS_CTRL, 32'h0000FFFF, 32'h0000001A);
    bus(1'b1, OFS_DUTY, 32'h00000011);
    rd(OFS_DUTY, 32'h0000007F, 32'h00000011);
    chk("chan_no_main", 32'h0, {20'h0, chan});
    stop_test();
  end
endmodule
`default_nettype wire
